// [core/fpt_core.sv]
`default_nettype none
module fpt_core #(
  parameter int ERASE_CYCLES = fpt_pkg::ERASE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic nv_blank,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] core_clock_divider,
  input wire logic irq_pending,
  input wire fpt_pkg::fpt_acc_t acc,
  output logic acc_ready,
  output logic acc_done,
  output logic dbg_read_en,
  output logic flash_stall,
  output var fpt_pkg::fpt_op_t flash_op
);
  localparam int CW = fpt_pkg::CNT_W;
  localparam logic [CW-1:0] ERASE_N = CW'(ERASE_CYCLES - 1);
  localparam logic [CW-1:0] WRITE_N = CW'(fpt_pkg::WRITE_CYC - 1);
  localparam logic [CW-1:0] ABORT_N = CW'(fpt_pkg::ABORT_CYC - 2);

  function automatic logic [4:0] grp_of(logic [15:0] a);
    logic [6:0] pg;
    pg = a[fpt_pkg::PAGE_LSB +: 7];
    return (pg >= fpt_pkg::TOP_PAGE) ? fpt_pkg::TOP_GRP : pg[6:2];
  endfunction

  function automatic logic [CW-1:0] acc_cycles(fpt_pkg::fpt_acc_t r,
                                               logic [2:0] cdv);
    int f;
    int b;
    int d;
    int x;
    int n;
    int w;
    n = int'(r.n);
    w = fpt_pkg::WRITE_CYC;
    f = (r.src_flash && r.instr32 && cdv == 3'h0) ? 2 : 1;
    b = !r.branch ? 0 : !r.src_flash ? 2 : (cdv == 3'h0) ? 5 : 1;
    unique case (r.kind)
      fpt_pkg::DK_NONE: d = 0;
      fpt_pkg::DK_SRAM: d = 1;
      fpt_pkg::DK_LDW: d = 2;
      fpt_pkg::DK_LDH: d = 1;
      fpt_pkg::DK_LDM: d = 2 * n;
      fpt_pkg::DK_STH: d = w;
      fpt_pkg::DK_STW: d = 2 * w;
      fpt_pkg::DK_STM: d = 2 * n * w;
    endcase
    if (!r.src_flash || r.kind == fpt_pkg::DK_NONE ||
        r.kind == fpt_pkg::DK_SRAM)
      x = 0;
    else if (r.kind == fpt_pkg::DK_LDM || r.kind == fpt_pkg::DK_STM)
      x = n;
    else
      x = 1;
    return CW'(f + b + x + d);
  endfunction

  logic [31:0] live_prot, next_live;
  logic [31:0] saved_prot, next_saved;
  logic [31:0] stored_key, next_key;
  logic key_set, next_kset;
  logic [15:0] adr, next_adr;
  logic [15:0] dat, next_dat;
  logic [fpt_pkg::MOD_W-1:0] mode, next_mode;
  logic st_done, next_done;
  logic st_fail, next_fail;
  logic st_abort, next_abort;
  fpt_pkg::fpt_ops_t op_state, next_state;
  logic [CW-1:0] op_cnt, next_cnt;
  logic [31:0] next_rdata;
  logic [31:0] stat_v;
  fpt_pkg::fpt_op_t next_fop;
  logic key_ok, perm, wr_ok, unprot, ewen, cmd_we;
  logic [1:0] lock;
  logic mass_go;

  always_comb
  begin
    next_live = live_prot;
    next_saved = saved_prot;
    next_key = stored_key;
    next_kset = key_set;
    next_adr = adr;
    next_dat = dat;
    next_mode = mode;
    next_done = st_done;
    next_fail = st_fail;
    next_abort = st_abort;
    next_state = op_state;
    next_cnt = op_cnt;
    next_fop = '0;
    key_ok = !key_set || {adr, dat} == stored_key; // [RULE5]
    perm = key_set && stored_key == fpt_pkg::KEY_PERM; // [RULE6]
    wr_ok = key_ok && !perm; // [RULE20]
    unprot = live_prot[grp_of(adr)]; // [RULE2] [RULE3]
    ewen = mode[fpt_pkg::MOD_EWEN];
    lock = mode[fpt_pkg::MOD_LOCK_LO +: 2];
    cmd_we = reg_we && reg_addr == fpt_pkg::OFF_CMD;
    mass_go = cmd_we && ewen && op_state == fpt_pkg::OP_IDLE &&
              reg_wdata[7:0] == fpt_pkg::CMD_MASS;
    stat_v = '0;
    stat_v[fpt_pkg::ST_BUSY] = op_state != fpt_pkg::OP_IDLE;
    stat_v[fpt_pkg::ST_DONE] = st_done;
    stat_v[fpt_pkg::ST_FAIL] = st_fail;
    stat_v[fpt_pkg::ST_ABORT] = st_abort;
    stat_v[fpt_pkg::ST_KSET] = key_set;
    stat_v[fpt_pkg::ST_PERM] = perm;
    // Clear on read first, so a set in the same cycle wins
    if (reg_re && reg_addr == fpt_pkg::OFF_STAT)
    begin
      next_done = 1'b0;
      next_fail = 1'b0;
      next_abort = 1'b0;
    end
    unique case (op_state)
      fpt_pkg::OP_IDLE: ;
      fpt_pkg::OP_RUN:
        if (mode[fpt_pkg::MOD_ABORT] && irq_pending) // [RULE18] [RULE19]
        begin
          next_state = fpt_pkg::OP_ABORT;
          next_cnt = ABORT_N;
        end
        else if (op_cnt == '0) // [RULE17]
        begin
          next_state = fpt_pkg::OP_IDLE;
          next_done = 1'b1;
        end
        else
          next_cnt = op_cnt - 1'b1;
      fpt_pkg::OP_ABORT:
        if (op_cnt == '0)
        begin
          next_state = fpt_pkg::OP_IDLE;
          next_abort = 1'b1;
        end
        else
          next_cnt = op_cnt - 1'b1;
      default: next_state = fpt_pkg::OP_IDLE;
    endcase
    if (reg_we)
    begin
      unique case (reg_addr)
        fpt_pkg::OFF_MOD: next_mode = reg_wdata[fpt_pkg::MOD_W-1:0];
        fpt_pkg::OFF_DAT: next_dat = reg_wdata[15:0];
        fpt_pkg::OFF_ADR: next_adr = reg_wdata[15:0]; // [RULE8]
        fpt_pkg::OFF_HID:
          if (wr_ok)
            next_live = reg_wdata; // [RULE4] [RULE20]
        fpt_pkg::OFF_PRO:
          if (wr_ok)
            next_saved = reg_wdata; // [RULE10] [RULE20]
        default: ;
      endcase
    end
    // One command at a time; anything else while busy is refused
    if (cmd_we)
    begin
      if (op_state != fpt_pkg::OP_IDLE || !ewen)
        next_fail = 1'b1;
      else
        unique case (reg_wdata[7:0])
          fpt_pkg::CMD_KEY:
            if (lock == fpt_pkg::LOCK_PAT && !key_set) // [RULE9]
            begin
              next_key = {adr, dat}; // [RULE5] [RULE8]
              next_kset = 1'b1;
              next_done = 1'b1;
            end
            else if (lock == fpt_pkg::LOCK_PAT && wr_ok) // [RULE10]
              next_done = 1'b1;
            else
              next_fail = 1'b1;
          fpt_pkg::CMD_HALF, fpt_pkg::CMD_PAGE:
            if (unprot) // [RULE2] [RULE3]
            begin
              next_state = fpt_pkg::OP_RUN;
              next_cnt = (reg_wdata[7:0] == fpt_pkg::CMD_PAGE) ?
                         ERASE_N : WRITE_N; // [RULE17]
              next_fop.valid = 1'b1;
              next_fop.kind = (reg_wdata[7:0] == fpt_pkg::CMD_PAGE) ?
                              fpt_pkg::OK_PAGE : fpt_pkg::OK_HALF;
              next_fop.addr = adr;
              next_fop.data = dat;
            end
            else
              next_fail = 1'b1;
          fpt_pkg::CMD_MASS:
          begin
            next_key = fpt_pkg::ERASED; // [RULE7]
            next_kset = 1'b0;
            next_saved = fpt_pkg::ERASED;
            next_live = fpt_pkg::ERASED;
            next_state = fpt_pkg::OP_RUN;
            next_cnt = ERASE_N;
            next_fop.valid = 1'b1;
            next_fop.kind = fpt_pkg::OK_MASS;
            next_fop.addr = adr;
            next_fop.data = dat;
          end
          default: next_fail = 1'b1;
        endcase
    end
    next_rdata = '0;
    if (reg_re)
      unique case (reg_addr)
        fpt_pkg::OFF_STAT: next_rdata = stat_v;
        fpt_pkg::OFF_MOD: next_rdata = {25'h0, mode};
        fpt_pkg::OFF_DAT: next_rdata = {16'h0, dat};
        fpt_pkg::OFF_ADR: next_rdata = {16'h0, adr};
        fpt_pkg::OFF_HID: next_rdata = live_prot;
        fpt_pkg::OFF_PRO: next_rdata = saved_prot;
        default: next_rdata = '0;
      endcase
  end

  // Saved mask and key model nonvolatile cells: only nv_blank and a mass erase clear them
  always_ff @(posedge clk)
  begin
    if (nv_blank)
    begin
      saved_prot <= fpt_pkg::ERASED;
      stored_key <= fpt_pkg::ERASED;
      key_set <= 1'b0;
    end
    else
    begin
      saved_prot <= next_saved;
      stored_key <= next_key;
      key_set <= next_kset;
    end
    if (reset)
    begin
      live_prot <= saved_prot; // [RULE21] [RULE4]
      dbg_read_en <= saved_prot[fpt_pkg::RD_BIT]; // [RULE1]
      adr <= '0;
      dat <= '0;
      mode <= '0;
      st_done <= 1'b0;
      st_fail <= 1'b0;
      st_abort <= 1'b0;
      op_state <= fpt_pkg::OP_IDLE;
      op_cnt <= '0;
      reg_rdata <= '0;
      flash_op <= '0;
      flash_stall <= 1'b0;
    end
    else
    begin
      live_prot <= next_live;
      dbg_read_en <= next_live[fpt_pkg::RD_BIT]; // [RULE1]
      adr <= next_adr;
      dat <= next_dat;
      mode <= next_mode;
      st_done <= next_done;
      st_fail <= next_fail;
      st_abort <= next_abort;
      op_state <= next_state;
      op_cnt <= next_cnt;
      reg_rdata <= next_rdata;
      flash_op <= next_fop;
      flash_stall <= next_state != fpt_pkg::OP_IDLE; // [RULE17]
    end
  end

  logic acc_busy, next_abusy;
  logic acc_flash, next_aflash;
  logic [CW-1:0] acc_cnt, next_acnt;
  logic next_adone;

  always_comb
  begin
    next_abusy = acc_busy;
    next_aflash = acc_flash;
    next_acnt = acc_cnt;
    next_adone = 1'b0;
    if (acc_busy)
    begin
      // Flash-sourced code cannot run while the array is busy
      if (acc_flash && op_state != fpt_pkg::OP_IDLE) // [RULE17]
        next_acnt = acc_cnt;
      else if (acc_cnt == '0)
      begin
        next_abusy = 1'b0;
        next_adone = 1'b1;
      end
      else
        next_acnt = acc_cnt - 1'b1;
    end
    else if (acc.valid)
    begin
      next_abusy = 1'b1;
      next_aflash = acc.src_flash;
      // [RULE11] [RULE12] [RULE13] [RULE14] [RULE15] [RULE16]
      next_acnt = acc_cycles(acc, core_clock_divider) - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      acc_busy <= 1'b0;
      acc_flash <= 1'b0;
      acc_cnt <= '0;
      acc_done <= 1'b0;
      acc_ready <= 1'b0;
    end
    else
    begin
      acc_busy <= next_abusy;
      acc_flash <= next_aflash;
      acc_cnt <= next_acnt;
      acc_done <= next_adone;
      acc_ready <= !next_abusy;
    end
  end

  logic rst_d;
  always_ff @(posedge clk)
  begin
    rst_d <= reset;
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_mass_cmd;
    mass_go;
  endsequence
  sequence s_page_cmd;
    cmd_we && ewen && op_state == fpt_pkg::OP_IDLE && unprot &&
    reg_wdata[7:0] == fpt_pkg::CMD_PAGE;
  endsequence
  sequence s_sram_branch;
    acc.valid && acc_ready && !acc.src_flash && acc.branch &&
    acc.kind == fpt_pkg::DK_NONE;
  endsequence

  property p_dbg;
    reg_we && reg_addr == fpt_pkg::OFF_HID && wr_ok
    |=> dbg_read_en == $past(reg_wdata[fpt_pkg::RD_BIT]);
  endproperty
  a_dbg: assert property (p_dbg) // [RULE1]
    else $error("debug read gate differs from live bit 31");
  property p_top_grp;
    flash_op.valid && flash_op.kind != fpt_pkg::OK_MASS &&
    flash_op.addr[fpt_pkg::PAGE_LSB +: 7] >= fpt_pkg::TOP_PAGE
    |-> live_prot[fpt_pkg::TOP_GRP];
  endproperty
  a_top_grp: assert property (p_top_grp) // [RULE2]
    else $error("top page group written while protected");
  property p_grp;
    flash_op.valid && flash_op.kind != fpt_pkg::OK_MASS
    |-> live_prot[grp_of(flash_op.addr)];
  endproperty
  a_grp: assert property (p_grp) // [RULE3]
    else $error("protected page group was programmed");
  property p_badkey;
    reg_we && reg_addr == fpt_pkg::OFF_HID && !wr_ok
    |=> $stable(live_prot);
  endproperty
  a_badkey: assert property (p_badkey) // [RULE20]
    else $error("live protection changed without key");
  property p_key_once;
    key_set && !mass_go && !nv_blank |=> $stable(stored_key);
  endproperty
  a_key_once: assert property (p_key_once) // [RULE5]
    else $error("stored key changed after being set");
  property p_perm;
    perm && !mass_go && !nv_blank |=> $stable(saved_prot);
  endproperty
  a_perm: assert property (p_perm) // [RULE6]
    else $error("permanent protection was altered");
  property p_mass;
    s_mass_cmd |=> stored_key == fpt_pkg::ERASED && !key_set &&
                   live_prot == fpt_pkg::ERASED;
  endproperty
  a_mass: assert property (p_mass) // [RULE7]
    else $error("mass erase did not reset the key");
  property p_stall;
    s_page_cmd |=> flash_stall [*8];
  endproperty
  a_stall: assert property (p_stall) // [RULE17]
    else $error("no stall during page erase");
  property p_abort;
    op_state == fpt_pkg::OP_RUN && mode[fpt_pkg::MOD_ABORT] && irq_pending
    |-> ##[1:10] !flash_stall;
  endproperty
  a_abort: assert property (p_abort) // [RULE18]
    else $error("abort took more than ten cycles");
  property p_reload;
    rst_d |-> live_prot == saved_prot;
  endproperty
  a_reload: assert property (p_reload) // [RULE21]
    else $error("live protection not reloaded at reset");
  property p_sram_br;
    s_sram_branch |=> !acc_done [*3] ##1 acc_done;
  endproperty
  a_sram_br: assert property (p_sram_br) // [RULE12]
    else $error("SRAM branch did not take three cycles");
endmodule
`default_nettype wire

// [core/fpt_pkg.sv]
// Behaviour
// RULE1: Debug reads of the whole 64 kB block pass only while bit 31 is set.
// RULE2: Bit 30 guards pages 120 to 127; cleared means write protected.
// RULE3: Bits 29..0 each guard four pages of 0..119; cleared protects.
// RULE4: Direct writes to the live register are volatile, lost at power.
// RULE5: First committed key is stored once, then needed for every change.
// RULE6: Key 0xDEADDEAD makes protection permanent until a mass erase.
// RULE7: Mass erase sets the key to all ones and erases user code.
// RULE8: Software writes saved mask, then key high in address, low in data.
// RULE9: Software sets lock field 1,0 and mode bit 3, then command 0x0C.
// RULE10: Repeating the key sequence with a new saved mask changes it.
// RULE11: SRAM fetch one cycle; SRAM data plus one, flash word plus two.
// RULE12: SRAM branch costs one fetch plus two refill cycles.
// RULE13: Flash fetch 1, or 2 for 32-bit at divider 0; dead time first.
// RULE14: Flash branch adds one decode cycle, plus four fills at divider 0.
// RULE15: Loads: dead 1, word 2, half 1; multiple N dead, 2N data.
// RULE16: Stores 50 us per halfword, word twice, multiple 2N times.
// RULE17: Flash code stalls in erase 20 ms per page or write 50 us.
// RULE18: With abort on, an interrupt ends erase or write within 10 cycles.
// RULE19: Software sets mode bit 1 to allow abort; else operations finish.
// RULE20: Protection writes with a wrong key are ignored.
// RULE21: Saved protection is loaded into the live register at every reset.
`default_nettype none
package fpt_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int ERASE_MS = 20;
  localparam int WRITE_US = 50;
  localparam int ERASE_CYC = (ERASE_MS * CLK_HZ + 999) / 1000;
  localparam int WRITE_CYC = (WRITE_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int ABORT_CYC = 10;
  localparam int CNT_W = 20;
  localparam logic [7:0] OFF_STAT = 8'h00;
  localparam logic [7:0] OFF_MOD = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;
  localparam logic [7:0] OFF_DAT = 8'h0c;
  localparam logic [7:0] OFF_ADR = 8'h10;
  localparam logic [7:0] OFF_PRO = 8'h1c;
  localparam logic [7:0] OFF_HID = 8'h20;
  localparam int MOD_ABORT = 1;
  localparam int MOD_EWEN = 3;
  localparam int MOD_LOCK_LO = 5;
  localparam int MOD_W = 7;
  localparam logic [1:0] LOCK_PAT = 2'h2;
  localparam logic [7:0] CMD_HALF = 8'h02;
  localparam logic [7:0] CMD_PAGE = 8'h05;
  localparam logic [7:0] CMD_MASS = 8'h06;
  localparam logic [7:0] CMD_KEY = 8'h0c;
  localparam logic [31:0] KEY_PERM = 32'hdeaddead;
  localparam logic [31:0] ERASED = 32'hffffffff;
  localparam int RD_BIT = 31;
  localparam logic [4:0] TOP_GRP = 5'h1e;
  localparam logic [6:0] TOP_PAGE = 7'h78;
  localparam int PAGE_LSB = 9;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_ABORT = 3;
  localparam int ST_KSET = 4;
  localparam int ST_PERM = 5;
  typedef enum logic [2:0] {
    DK_NONE, DK_SRAM, DK_LDW, DK_LDH, DK_LDM, DK_STH, DK_STW, DK_STM
  } fpt_dk_t;
  typedef struct packed {
    logic valid;
    logic src_flash;
    logic instr32;
    logic branch;
    fpt_dk_t kind;
    logic [4:0] n;
  } fpt_acc_t;
  typedef enum logic [1:0] {OK_HALF, OK_PAGE, OK_MASS} fpt_opk_t;
  typedef struct packed {
    logic valid;
    fpt_opk_t kind;
    logic [15:0] addr;
    logic [15:0] data;
  } fpt_op_t;
  typedef enum logic [1:0] {
    OP_IDLE = 2'b00, OP_RUN = 2'b01, OP_ABORT = 2'b11
  } fpt_ops_t;
endpackage
`default_nettype wire

// [tb/fpt_core_bench.sv]
`default_nettype none
module fpt_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // Short erase keeps the run small
  localparam int ERC = 40;
  logic clk, reset, nv_blank, reg_we, reg_re, irq, dbg, stall;
  logic acc_ready, acc_done, start, busy;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [2:0] cd;
  logic [15:0] lat;
  fpt_pkg::fpt_acc_t acc, req;
  fpt_pkg::fpt_op_t fop, last_op;
  int fail_count, n_checks, n;

  fpt_core #(.ERASE_CYCLES(ERC)) dut_u (.clk(clk), .reset(reset),
    .nv_blank(nv_blank), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .core_clock_divider(cd), .irq_pending(irq), .acc(acc),
    .acc_ready(acc_ready), .acc_done(acc_done), .dbg_read_en(dbg),
    .flash_stall(stall), .flash_op(fop));
  fpt_core_partner partner_u (.clk(clk), .reset(reset), .start(start),
    .req(req), .acc_ready(acc_ready), .acc_done(acc_done), .acc(acc),
    .busy(busy), .lat(lat));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (fop.valid === 1'b1)
      last_op <= fop;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    chk(32'h0, 32'h1);
    end_sim();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  // Counts cycles with the stall flag high
  task automatic op_wait(input int lim);
    n = 0;
    repeat (lim)
    begin
      #1;
      if (stall === 1'b1)
        n++;
      else if (n > 0)
        break;
      @(posedge clk);
    end
    if (stall !== 1'b0)
      hang();
  endtask

  task automatic acc_run(input logic fl, i32, br,
    input fpt_pkg::fpt_dk_t k, input logic [4:0] nn,
    input logic [2:0] c, input int exp);
    @(posedge clk);
    cd <= c;
    req <= '{1'b1, fl, i32, br, k, nn};
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (6000)
    begin
      @(posedge clk);
      #1;
      if (busy === 1'b0)
        break;
    end
    if (busy !== 1'b0)
      hang();
    chk({16'h0, lat}, exp);
  endtask

  task automatic t_reset();
    rd(fpt_pkg::OFF_HID);
    chk(rv, 32'hffffffff);
    rd(fpt_pkg::OFF_PRO);
    chk(rv, 32'hffffffff);
    chk({31'h0, dbg}, 32'h1);
    wr(fpt_pkg::OFF_HID, 32'h7fffffff);
    rd(fpt_pkg::OFF_HID);
    chk(rv, 32'h7fffffff);
    chk({31'h0, dbg}, 32'h0);
    rd(8'h44);
    chk(rv, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_prot();
    logic [15:0] pa [4] = '{16'hf000, 16'hfe00, 16'h0800, 16'h0e00};
    wr(fpt_pkg::OFF_HID, 32'hbffffffd);
    wr(fpt_pkg::OFF_MOD, 32'h8);
    foreach (pa[i])
    begin
      wr(fpt_pkg::OFF_ADR, {16'h0, pa[i]});
      wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_HALF));
      rd(fpt_pkg::OFF_STAT);
      chk({31'h0, rv[2]}, 32'h1);
      chk({31'h0, stall}, 32'h0);
    end
    wr(fpt_pkg::OFF_DAT, 32'hbeef);
    wr(fpt_pkg::OFF_ADR, 32'h1000);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_HALF));
    op_wait(1400);
    chk(n, fpt_pkg::WRITE_CYC);
    chk({last_op.addr, last_op.data}, 32'h1000beef);
    chk(32'(last_op.kind), 32'(fpt_pkg::OK_HALF));
    rd(fpt_pkg::OFF_STAT);
    chk({31'h0, rv[1]}, 32'h1);
    $display("test protect done");
  endtask

  task automatic t_abort();
    wr(fpt_pkg::OFF_MOD, 32'ha);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_PAGE));
    irq <= 1'b1;
    op_wait(100);
    chk(32'(n <= 12), 32'h1);
    chk(32'(last_op.kind), 32'(fpt_pkg::OK_PAGE));
    rd(fpt_pkg::OFF_STAT);
    chk({31'h0, rv[3]}, 32'h1);
    wr(fpt_pkg::OFF_MOD, 32'h8);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_PAGE));
    op_wait(100);
    irq <= 1'b0;
    chk(n, ERC);
    $display("test abort done");
  endtask

  task automatic t_refuse();
    wr(fpt_pkg::OFF_HID, 32'hffffffff);
    wr(fpt_pkg::OFF_ADR, 32'hfe00);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_HALF));
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_PAGE));
    op_wait(1400);
    chk(n, fpt_pkg::WRITE_CYC - 2);
    chk({16'h0, last_op.addr}, 32'hfe00);
    rd(fpt_pkg::OFF_STAT);
    chk(rv, 32'h6);
    wr(fpt_pkg::OFF_MOD, 32'h28);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_KEY));
    rd(fpt_pkg::OFF_STAT);
    chk(rv, 32'h4);
    wr(fpt_pkg::OFF_MOD, 32'h0);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_HALF));
    rd(fpt_pkg::OFF_STAT);
    chk(rv, 32'h4);
    wr(fpt_pkg::OFF_HID, 32'hbffffffd);
    $display("test refuse done");
  endtask

  task automatic t_key();
    wr(fpt_pkg::OFF_PRO, 32'hbffffff0);
    wr(fpt_pkg::OFF_ADR, 32'h1234);
    wr(fpt_pkg::OFF_DAT, 32'h5678);
    wr(fpt_pkg::OFF_MOD, 32'h48);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_KEY));
    rd(fpt_pkg::OFF_STAT);
    chk({31'h0, rv[4]}, 32'h1);
    wr(fpt_pkg::OFF_DAT, 32'h5679);
    wr(fpt_pkg::OFF_HID, 32'h0);
    rd(fpt_pkg::OFF_HID);
    chk(rv, 32'hbffffffd);
    wr(fpt_pkg::OFF_DAT, 32'h5678);
    wr(fpt_pkg::OFF_HID, 32'h3fffffff);
    rd(fpt_pkg::OFF_HID);
    chk(rv, 32'h3fffffff);
    chk({31'h0, dbg}, 32'h0);
    wr(fpt_pkg::OFF_PRO, 32'hfffffff0);
    wr(fpt_pkg::OFF_MOD, 32'h48);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_KEY));
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(fpt_pkg::OFF_HID);
    chk(rv, 32'hfffffff0);
    $display("test key done");
  endtask

  task automatic t_perm();
    wr(fpt_pkg::OFF_MOD, 32'h8);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_MASS));
    op_wait(100);
    chk(n, ERC);
    rd(fpt_pkg::OFF_HID);
    chk(rv, 32'hffffffff);
    rd(fpt_pkg::OFF_PRO);
    chk(rv, 32'hffffffff);
    rd(fpt_pkg::OFF_STAT);
    chk({31'h0, rv[4]}, 32'h0);
    wr(fpt_pkg::OFF_PRO, 32'hfffffffb);
    wr(fpt_pkg::OFF_ADR, 32'hdead);
    wr(fpt_pkg::OFF_DAT, 32'hdead);
    wr(fpt_pkg::OFF_MOD, 32'h48);
    wr(fpt_pkg::OFF_CMD, 32'(fpt_pkg::CMD_KEY));
    rd(fpt_pkg::OFF_STAT);
    chk({31'h0, rv[5]}, 32'h1);
    wr(fpt_pkg::OFF_PRO, 32'h0);
    rd(fpt_pkg::OFF_PRO);
    chk(rv, 32'hfffffffb);
    $display("test permanent done");
  endtask

  task automatic t_time();
    acc_run(0, 0, 0, fpt_pkg::DK_NONE, 0, 0, 1);
    acc_run(0, 0, 0, fpt_pkg::DK_SRAM, 0, 0, 2);
    acc_run(0, 0, 0, fpt_pkg::DK_LDW, 0, 0, 3);
    acc_run(0, 0, 1, fpt_pkg::DK_NONE, 0, 0, 3);
    acc_run(1, 0, 0, fpt_pkg::DK_NONE, 0, 0, 1);
    acc_run(1, 1, 0, fpt_pkg::DK_NONE, 0, 0, 2);
    acc_run(1, 1, 0, fpt_pkg::DK_NONE, 0, 1, 1);
    acc_run(1, 0, 1, fpt_pkg::DK_NONE, 0, 0, 6);
    acc_run(1, 0, 1, fpt_pkg::DK_NONE, 0, 2, 2);
    acc_run(1, 1, 0, fpt_pkg::DK_LDW, 0, 0, 5);
    acc_run(1, 0, 0, fpt_pkg::DK_LDH, 0, 0, 3);
    acc_run(1, 0, 0, fpt_pkg::DK_LDM, 16, 0, 49);
    acc_run(1, 0, 0, fpt_pkg::DK_STH, 0, 1, 1252);
    acc_run(1, 0, 0, fpt_pkg::DK_STW, 0, 1, 2502);
    acc_run(1, 0, 0, fpt_pkg::DK_STM, 2, 1, 5003);
    $display("test timing done");
  endtask

  initial
  begin
    reset = 1'b1;
    nv_blank = 1'b1;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    irq = 1'b0;
    cd = 3'h0;
    start = 1'b0;
    req = '0;
    fail_count = 0;
    n_checks = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    nv_blank <= 1'b0;
    t_reset();
    t_prot();
    t_abort();
    t_refuse();
    t_key();
    t_perm();
    t_time();
    end_sim();
  end
endmodule
`default_nettype wire

// [tb/fpt_core_partner.sv]
`default_nettype none
module fpt_core_partner (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire fpt_pkg::fpt_acc_t req,
  input wire logic acc_ready,
  input wire logic acc_done,
  output var fpt_pkg::fpt_acc_t acc,
  output logic busy,
  output logic [15:0] lat
);
  timeunit 1ns;
  timeprecision 1ns;
  logic taken;
  // Fields scrambled once taken, so a late sampler never sees stale data
  always @(posedge clk)
  begin
    if (reset)
    begin
      acc <= '0;
      busy <= 1'b0;
      taken <= 1'b0;
      lat <= 16'h0;
    end
    else if (start)
    begin
      acc <= req;
      busy <= 1'b1;
    end
    else if (acc.valid && acc_ready)
    begin
      acc <= {1'b0, ~acc[10:0]};
      taken <= 1'b1;
      lat <= 16'h0;
    end
    else if (taken)
    begin
      // Edges from take up to the one that shows done
      if (acc_done)
      begin
        busy <= 1'b0;
        taken <= 1'b0;
      end
      else
        lat <= lat + 16'h1;
    end
  end
endmodule
`default_nettype wire
